// >>> verilog/sbs_pkg.sv
// Package of constants and types for the synchronous burst SRAM port
`default_nettype none
package sbs_pkg;
  // ***********************************************
  // Geometry
  // ***********************************************
  localparam int ADDR_W = 20;
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;
  // ***********************************************
  // Reset values
  // ***********************************************
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  // ***********************************************
  // Access states
  // ***********************************************
  typedef enum logic [3:0] {
    SBS_DESEL = 4'h1,
    SBS_READ_FIRST = 4'h2,
    SBS_READ = 4'h4,
    SBS_WRITE = 4'h8
  } sbs_state_t;
endpackage : sbs_pkg
`default_nettype wire

// >>> verilog/sbs_burst_ctr.sv
// Two-bit burst counter with linear or interleaved order
`default_nettype none
module sbs_burst_ctr #(
  parameter int W = sbs_pkg::BURST_W
) (
  // Clock and control
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic advance,
  input wire logic interleaved,
  // Start value and output
  input wire logic [W-1:0] load_val,
  output logic [W-1:0] burst_low
);
  logic [W-1:0] base_reg;
  logic [W-1:0] beat_reg;

  // ***********************************************
  // Counter state
  // ***********************************************
  // Load on a strobe, step on advance; wraps within four
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      base_reg <= sbs_pkg::BURST_RST;
      beat_reg <= sbs_pkg::BURST_RST;
    end else if (clk_en) begin
      if (load) begin
        base_reg <= load_val;
        beat_reg <= sbs_pkg::BURST_RST;
      end else if (advance) begin
        beat_reg <= beat_reg + W'(1);
      end
    end
  end

  // Linear adds modulo four, interleaved XORs the beat
  assign burst_low = interleaved ? (base_reg ^ beat_reg)
                                 : (base_reg + beat_reg);
endmodule : sbs_burst_ctr
`default_nettype wire

// >>> verilog/sbs_sram_port.sv
// Host port of a flowthrough synchronous burst SRAM, with its array
`default_nettype none
module sbs_sram_port #(
  parameter int ADDR_W = sbs_pkg::ADDR_W,
  parameter int LANES = sbs_pkg::LANES,
  parameter int LANE_W = sbs_pkg::LANE_W
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Address and strobes
  input wire logic [ADDR_W-1:0] addr,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  // Chip selects
  input wire logic chip_sel_first_n,
  input wire logic chip_sel_second,
  input wire logic chip_sel_third_n,
  // Write controls
  input wire logic byte_write_enable_n,
  input wire logic global_write_n,
  input wire logic byte_sel_lane0_n,
  input wire logic byte_sel_lane1_n,
  // Static and asynchronous controls
  input wire logic burst_order,
  input wire logic out_enable_n,
  // Data pins, parity bits in the top bit of each lane
  input wire logic [LANES*LANE_W-1:0] data_in,
  output logic [LANES*LANE_W-1:0] data_out,
  output logic data_oe
);
  localparam int DW = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // ***********************************************
  // Input synchronisers
  // ***********************************************
  // Pins other than output enable come from outside the clock domain: two flops each
  localparam int SW = ADDR_W + 11 + DW;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic [SW-1:0] pins;
  assign pins = {addr, proc_addr_strobe_n, ctrl_addr_strobe_n,
                 burst_advance_n, chip_sel_first_n, chip_sel_second,
                 chip_sel_third_n, byte_write_enable_n, global_write_n,
                 byte_sel_lane1_n, byte_sel_lane0_n, burst_order, data_in};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (clk_en) begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  logic [ADDR_W-1:0] s_addr;
  logic s_proc_addr_strobe_n_n, s_ctrl_addr_strobe_n_n, s_adv_n, s_ce1_n, s_ce2, s_ce3_n;
  logic s_bwe_n, s_gw_n, s_bs1_n, s_bs0_n, s_order;
  logic [DW-1:0] s_din;
  assign {s_addr, s_proc_addr_strobe_n_n, s_ctrl_addr_strobe_n_n, s_adv_n, s_ce1_n, s_ce2, s_ce3_n,
          s_bwe_n, s_gw_n, s_bs1_n, s_bs0_n, s_order, s_din} = sync2_reg;

  // ***********************************************
  // Select and strobe decode
  // ***********************************************
  logic selected, proc_strobe, ctrl_strobe, start, write_now;
  logic [LANES-1:0] lane_we;
  assign selected = !s_ce1_n && s_ce2 && !s_ce3_n;
  // First enable high masks the processor strobe as a start; it still blocks the controller strobe
  assign proc_strobe = !s_proc_addr_strobe_n_n && !s_ce1_n;
  // Processor strobe takes precedence when both are low
  assign ctrl_strobe = !s_ctrl_addr_strobe_n_n && s_proc_addr_strobe_n_n;
  assign start = proc_strobe || ctrl_strobe;

  // Lane enables: global write overrides the byte controls
  always_comb begin
    if (!s_gw_n) begin
      lane_we = '1;
    end else if (!s_bwe_n) begin
      lane_we = ~{s_bs1_n, s_bs0_n};
    end else begin
      lane_we = '0;
    end
  end
  assign write_now = |lane_we;

  // ***********************************************
  // Cycle decode helpers
  // ***********************************************
  // A cycle is live from its strobe until a deselecting strobe
  function automatic logic in_access(input sbs_pkg::sbs_state_t st);
    return st != sbs_pkg::SBS_DESEL;
  endfunction : in_access

  // Kind of the next cycle; a read out of deselect keeps the pins
  // floating for one clock, whatever output enable says
  function automatic sbs_pkg::sbs_state_t next_access(input logic wr,
      input logic first);
    if (wr) begin
      return sbs_pkg::SBS_WRITE;
    end else if (first) begin
      return sbs_pkg::SBS_READ_FIRST;
    end else begin
      return sbs_pkg::SBS_READ;
    end
  endfunction : next_access

  // ***********************************************
  // Address register and burst counter
  // ***********************************************
  logic [ADDR_W-1:0] addr_reg;
  logic [1:0] burst_low;
  logic load_ctr, adv_ctr;
  sbs_pkg::sbs_state_t state_reg;
  assign load_ctr = start && selected;
  assign adv_ctr = !s_adv_n && !start && in_access(state_reg);

  // Upper address bits held from the strobe edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_reg <= sbs_pkg::ADDR_RST;
    end else if (clk_en && load_ctr) begin
      addr_reg <= s_addr;
    end
  end

  sbs_burst_ctr #(.W(2)) u_ctr (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .load(load_ctr),
    .advance(adv_ctr),
    .interleaved(s_order),
    .load_val(s_addr[1:0]),
    .burst_low(burst_low)
  );

  logic [ADDR_W-1:0] cur_addr;
  assign cur_addr = {addr_reg[ADDR_W-1:2], burst_low};

  // ***********************************************
  // Access state
  // ***********************************************
  // Deselect only on a strobe edge with the chip not selected
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= sbs_pkg::SBS_DESEL;
    end else if (clk_en) begin
      if (start && !selected) begin
        state_reg <= sbs_pkg::SBS_DESEL;
      end else if (start || in_access(state_reg)) begin
        case (state_reg)
          sbs_pkg::SBS_DESEL: begin
            state_reg <= next_access(write_now, 1'b1);
          end
          sbs_pkg::SBS_READ_FIRST, sbs_pkg::SBS_READ,
          sbs_pkg::SBS_WRITE: begin
            state_reg <= next_access(write_now, 1'b0);
          end
          default: begin
            state_reg <= sbs_pkg::SBS_DESEL;
          end
        endcase
      end
    end
  end

  // ***********************************************
  // Memory array
  // ***********************************************
  logic [DW-1:0] mem [DEPTH];

  // A strobe edge opens a new address; its data phase is the next
  // edge, so nothing lands on the old address at the strobe itself
  logic write_fire;
  assign write_fire = clk_en && state_reg == sbs_pkg::SBS_WRITE && !start;

  // Write data lands one edge after the address, per lane
  always_ff @(posedge sys_clk) begin
    if (write_fire) begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_we[i]) begin
          mem[cur_addr][i*LANE_W +: LANE_W] <= s_din[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Flowthrough read of the address registered at the last edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_out <= '0;
    end else if (clk_en) begin
      data_out <= mem[cur_addr];
    end
  end

  // ***********************************************
  // Output drive
  // ***********************************************
  // Output enable acts without the clock; masked in write,
  // deselect and first read clock. Trade-off: data_out lags the
  // flowthrough by one flop so outputs come from registers.
  assign data_oe = !out_enable_n
                   && state_reg == sbs_pkg::SBS_READ;
endmodule : sbs_sram_port
`default_nettype wire

// >>> verification/sbs_port_sva.sv
// Pin-level assertions for the burst SRAM port
`default_nettype none
module sbs_port_sva (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Bus controls
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic chip_sel_first_n,
  input wire logic chip_sel_second,
  input wire logic chip_sel_third_n,
  input wire logic byte_write_enable_n,
  input wire logic global_write_n,
  input wire logic out_enable_n,
  // Data side
  input wire logic [17:0] data_out,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************
  // Access sequences
  // ****************************
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Whole selection, all three enables
  wire logic sel = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
  sequence desel_s;
    (!ctrl_addr_strobe_n && !chip_sel_second) [*5];
  endsequence
  sequence rd_s;
    !ctrl_addr_strobe_n && proc_addr_strobe_n && sel && global_write_n &&
      byte_write_enable_n && !out_enable_n;
  endsequence
  sequence wr_s;
    !ctrl_addr_strobe_n && sel && !global_write_n ##1 ctrl_addr_strobe_n;
  endsequence
  sequence beats_s;
    (!burst_advance_n && proc_addr_strobe_n && ctrl_addr_strobe_n &&
      !out_enable_n) [*5];
  endsequence
  // Latency slack of the input synchronisers is in the delays
  oe_pin_a: assert property (data_oe |-> !out_enable_n)
    else $error("pins driven with output enable high");
  frz_out_a: assert property (!clk_en |=> $stable(data_out))
    else $error("read data moved on a frozen edge");
  frz_oe_a: assert property (
    !clk_en ##1 $stable(out_enable_n) |-> $stable(data_oe))
    else $error("drive changed on a frozen edge");
  desel_float_a: assert property (desel_s |-> !data_oe)
    else $error("pins driven while deselected");
  write_float_a: assert property (wr_s |-> ##2 !data_oe [*2])
    else $error("pins driven in write data phase");
  first_mask_a: assert property (
    desel_s ##1 rd_s |-> !data_oe [*4])
    else $error("output enable not masked on first read clock");
  read_drive_a: assert property (rd_s ##1 beats_s |-> data_oe)
    else $error("read burst never drove the pins");
  proc_ignore_a: assert property (
    data_oe ##1 (!proc_addr_strobe_n && chip_sel_first_n &&
      ctrl_addr_strobe_n && !out_enable_n) [*5] |-> data_oe)
    else $error("processor strobe taken with first enable high");
endmodule : sbs_port_sva
bind sbs_sram_port sbs_port_sva u_sva (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .clk_en(clk_en),
  .proc_addr_strobe_n(proc_addr_strobe_n),
  .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
  .burst_advance_n(burst_advance_n),
  .chip_sel_first_n(chip_sel_first_n),
  .chip_sel_second(chip_sel_second),
  .chip_sel_third_n(chip_sel_third_n),
  .byte_write_enable_n(byte_write_enable_n),
  .global_write_n(global_write_n),
  .out_enable_n(out_enable_n),
  .data_out(data_out),
  .data_oe(data_oe)
);
`default_nettype wire

// >>> verification/sbs_ctl_model.sv
// Bus controller model that drives the burst SRAM port pins
`default_nettype none
module sbs_ctl_model (
  // Clock
  input wire logic sys_clk,
  // Address, packed controls, data
  output logic [19:0] a,
  output logic [9:0] c,
  output logic [17:0] d
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************
  // Bus cycles
  // ****************************
  // One cycle, launched 2 ns after the edge, held a whole period
  task automatic cyc(input logic [19:0] na, input logic [9:0] nc,
      input logic drv, input logic [17:0] nd);
    @(posedge sys_clk);
    #2;
    a = na;
    c = nc; // Advance high unless a beat is wanted
    d = drv ? nd : ~d; // Released lines toggle, never stale data
  endtask : cyc
  // Repeat one control pattern at the current address
  task automatic rep(input logic [9:0] nc, input int n);
    repeat (n) cyc(a, nc, 1'b0, 18'h0);
  endtask : rep
  initial begin
    a = 20'h00000;
    c = 10'h3af; // Idle: strobes, advance, writes high
    d = 18'h00000;
  end
endmodule : sbs_ctl_model
`default_nettype wire

// >>> verification/sync_burst_sram_port_test.sv
// Self-checking testbench for the burst SRAM port
`default_nettype none
module sync_burst_sram_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************
  // Pins, model, design
  // ****************************
  localparam logic [9:0] IDLE = 10'h3af;
  localparam logic [9:0] RD = 10'h2af;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic burst_order = 1'b0;
  logic out_enable_n = 1'b0;
  logic [19:0] a;
  logic [9:0] c;
  logic [17:0] d;
  logic [17:0] data_out;
  logic data_oe;
  wire logic [17:0] data_in = data_oe ? data_out : d;
  logic [17:0] mem [bit [19:0]];
  int fail_count = 0;
  int cmp_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  sbs_sram_port DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .addr(a), .proc_addr_strobe_n(c[9]), .ctrl_addr_strobe_n(c[8]),
    .burst_advance_n(c[7]), .chip_sel_first_n(c[6]),
    .chip_sel_second(c[5]), .chip_sel_third_n(c[4]),
    .byte_write_enable_n(c[3]), .global_write_n(c[2]),
    .byte_sel_lane1_n(c[1]), .byte_sel_lane0_n(c[0]),
    .burst_order(burst_order), .out_enable_n(out_enable_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  sbs_ctl_model ctl (.sys_clk(sys_clk), .a(a), .c(c), .d(d));
  task automatic chk(input string n, input logic [17:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // Write w = {byte enable, global, lane1, lane0}; data one edge later
  task automatic wr(input logic [19:0] ad, input logic [17:0] v,
      input logic [3:0] w);
    // Turn the pins around first: the port still drives until its
    // synchronised view of the strobe arrives, two edges late
    out_enable_n = 1'b1;
    ctl.cyc(ad, {6'h2a, w}, 1'b0, 18'h0);
    ctl.cyc(ad, {6'h3a, w}, 1'b1, v);
    ctl.rep(IDLE, 2);
    for (int i = 0; i < 2; i++) begin
      if (!w[2] || (!w[3] && !w[i])) mem[ad][9*i+:9] = v[9*i+:9];
    end
  endtask : wr
  // Strobe s, k advance beats, then read data stands
  task automatic rd(input logic [19:0] ad, input logic [2:0] k,
      input logic [9:0] s);
    logic [1:0] lo;
    lo = burst_order ? ad[1:0] ^ k[1:0] : ad[1:0] + k[1:0];
    out_enable_n = 1'b0;
    ctl.cyc(ad, s, 1'b0, 18'h0);
    ctl.rep(10'h32f, int'(k));
    ctl.rep(IDLE, 6);
    chk("read data", data_out, mem[{ad[19:2], lo}]);
  endtask : rd
  // ****************************
  // Scenarios
  // ****************************
  task automatic t_write;
    logic [3:0] w [4] = '{4'hb, 4'h6, 4'h5, 4'hc};
    for (int i = 0; i < 4; i++) begin
      wr(20'h0a5a4, 18'h3c5a5 - 18'(i) * 18'h0a3f1, w[i]);
      rd(20'h0a5a4, 3'h0, RD);
    end
  endtask : t_write
  task automatic t_burst;
    for (int i = 0; i < 4; i++) begin
      wr(20'h031c0 | 20'(i), 18'h1e0f0 + 18'(i), 4'hb);
    end
    for (int o = 0; o < 2; o++) begin
      burst_order = o[0];
      for (int k = 0; k < 4; k++) rd(20'h031c1, 3'(k), RD);
    end
  endtask : t_burst
  task automatic t_proc;
    rd(20'h031c2, 3'h0, RD);
    ctl.cyc(20'h031c0, 10'h1ef, 1'b0, 18'h0);
    ctl.rep(10'h1ef, 4);
    ctl.rep(IDLE, 2);
    chk("ignored strobe", 18'(data_oe), 18'h1);
    rd(20'h031c3, 3'h0, 10'h1af);
    rd(20'h0a5a4, 3'h0, 10'h0af);
  endtask : t_proc
  task automatic t_oe;
    out_enable_n = 1'b1;
    ctl.rep(IDLE, 1);
    chk("drive off", 18'(data_oe), 18'h0);
    out_enable_n = 1'b0;
    ctl.rep(10'h28f, 6);
    chk("deselected", 18'(data_oe), 18'h0);
    rd(20'h031c0, 3'h5, RD);
    clk_en = 1'b0;
    ctl.cyc(20'h031c3, RD, 1'b0, 18'h0);
    ctl.rep(IDLE, 3);
    clk_en = 1'b1;
    ctl.rep(IDLE, 4);
    chk("frozen", data_out, mem[20'h031c1]);
    ctl.rep(10'h2bf, 5);
    chk("third enable", 18'(data_oe), 18'h0);
  endtask : t_oe
  task automatic end_sim;
    $display("Compared %0d, mismatched %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    ctl.rep(IDLE, 10);
    rst_n = 1'b1;
    ctl.rep(IDLE, 4);
    t_write();
    t_burst();
    t_proc();
    t_oe();
    end_sim();
  end
endmodule : sync_burst_sram_port_test
`default_nettype wire
